// ### rtl/rcal_regs.sv
// Calendar counters, alarm set points and their AXI4-Lite register slave.
`timescale 1ns/1ns
`default_nettype none
module rcal_regs (
   input  wire logic                                clk_in,
   input  wire logic                                rst_n_in,
   input  wire logic                                ce_in,
   input  wire logic                                month_carry_in,
   input  wire logic [7:0]                          cur_seconds_in,
   input  wire logic [7:0]                          cur_minutes_in,
   input  wire logic [rcal_pkg::ADDR_W-1:0]         s_axi_awaddr_in,
   input  wire logic                                s_axi_awvalid_in,
   output logic                                     s_axi_awready_out,
   input  wire logic [rcal_pkg::DATA_W-1:0]         s_axi_wdata_in,
   input  wire logic [3:0]                          s_axi_wstrb_in,
   input  wire logic                                s_axi_wvalid_in,
   output logic                                     s_axi_wready_out,
   output logic [1:0]                               s_axi_bresp_out,
   output logic                                     s_axi_bvalid_out,
   input  wire logic                                s_axi_bready_in,
   input  wire logic [rcal_pkg::ADDR_W-1:0]         s_axi_araddr_in,
   input  wire logic                                s_axi_arvalid_in,
   output logic                                     s_axi_arready_out,
   output logic [rcal_pkg::DATA_W-1:0]              s_axi_rdata_out,
   output logic [1:0]                               s_axi_rresp_out,
   output logic                                     s_axi_rvalid_out,
   input  wire logic                                s_axi_rready_in,
   output logic                                     alarm_match_out,
   output logic                                     irq_out
);

   typedef struct packed {
      logic [7:0]                  month;
      logic [7:0]                  year;
      logic [7:0]                  century;
      logic [7:0]                  alarm_sec;
      logic [7:0]                  alarm_min;
      logic [1:0]                  alarm_en;
      logic                        unlock;
      logic                        decimal;
      logic [1:0]                  status;
      logic [1:0]                  mask;
      logic                        alarm_match;
      logic                        irq;
      logic                        aw_got;
      logic                        w_got;
      logic [rcal_pkg::ADDR_W-1:0] aw_addr;
      logic [7:0]                  w_byte;
      logic                        w_lane;
      logic                        aw_rdy;
      logic                        w_rdy;
      logic                        bvalid;
      logic [1:0]                  bresp;
      logic                        ar_rdy;
      logic                        rvalid;
      logic [7:0]                  rbyte;
      logic [1:0]                  rresp;
   } rcal_state_s;

   rcal_state_s st_r;
   rcal_state_s st_nxt;
   logic        rst_q1_r;
   logic        rst_q2_r;
   logic        rst_n;
   logic        wr_now;
   logic [7:0]  wr_idx;
   logic        wr_ok;
   logic [7:0]  rd_idx;
   logic        rd_ok;
   logic        match_now;

   // The reset is released through two flops so that its removal is clean.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_q1_r <= 1'h0;
         rst_q2_r <= 1'h0;
      end else begin
         rst_q1_r <= 1'h1;
         rst_q2_r <= rst_q1_r;
      end
   end
   assign rst_n = rst_q2_r;

   // Word addresses only; anything outside the index space is unmapped.
   function automatic logic addr_ok(input logic [rcal_pkg::ADDR_W-1:0] a);
      addr_ok = (a[1:0] == 2'h0) && (a[rcal_pkg::ADDR_W-1:10] == 2'h0);
   endfunction : addr_ok

   function automatic logic idx_mapped(input logic [7:0] i);
      case (i)
         rcal_pkg::IDX_MONTH, rcal_pkg::IDX_YEAR, rcal_pkg::IDX_CENTURY,
         rcal_pkg::IDX_ALARM_SEC, rcal_pkg::IDX_ALARM_MIN,
         rcal_pkg::IDX_ALARM_CTRL, rcal_pkg::IDX_MODE_CTRL,
         rcal_pkg::IDX_STATUS, rcal_pkg::IDX_MASK: idx_mapped = 1'h1;
         default: idx_mapped = 1'h0;
      endcase
   endfunction : idx_mapped

   // One counting step; bit 8 flags the wrap back to the first value.
   // Decimal mode carries the ones digit into the tens digit at nine.
   function automatic logic [8:0] step(input logic [7:0] v,
                                       input logic [7:0] last,
                                       input logic [7:0] first,
                                       input logic       dec);
      logic [7:0] n;
      n = v + 8'h01;
      if (v == last) begin
         step = {1'h1, first};
      end else if (dec && (v[3:0] == rcal_pkg::DIGIT_LAST)) begin
         step = {1'h0, v[7:4] + 4'h1, 4'h0};
      end else begin
         step = {1'h0, n};
      end
   endfunction : step

   assign wr_now    = st_r.aw_got && st_r.w_got && !st_r.bvalid;
   assign wr_idx    = st_r.aw_addr[9:2];
   assign wr_ok     = addr_ok(st_r.aw_addr) && idx_mapped(wr_idx);
   assign rd_idx    = s_axi_araddr_in[9:2];
   assign rd_ok     = addr_ok(s_axi_araddr_in) && idx_mapped(rd_idx);
   // Raw register contents are compared, so both sides share one format.
   assign match_now = (st_r.alarm_en != 2'h0)
      && (!st_r.alarm_en[rcal_pkg::BIT_SEC_EN]
          || (st_r.alarm_sec == cur_seconds_in))
      && (!st_r.alarm_en[rcal_pkg::BIT_MIN_EN]
          || (st_r.alarm_min == cur_minutes_in));

   always_comb begin
      logic [8:0] m_step;
      logic [8:0] y_step;
      logic [8:0] c_step;
      logic [7:0] mlast;
      logic [7:0] ylast;
      logic [1:0] events;
      logic       rd_status;
      logic [7:0] rv;
      st_nxt    = st_r;
      m_step    = 9'h000;
      y_step    = 9'h000;
      c_step    = 9'h000;
      events    = 2'h0;
      rd_status = 1'h0;
      rv        = 8'h00;
      // The decimal flag as it stands now picks the counting limits.
      mlast = st_r.decimal ? rcal_pkg::MONTH_LAST_DEC
                           : rcal_pkg::MONTH_LAST_BIN;
      ylast = st_r.decimal ? rcal_pkg::YEAR_LAST_DEC
                           : rcal_pkg::YEAR_LAST_BIN;
      if (ce_in) begin
         // Calendar counting; runs whatever the lock state.
         if (month_carry_in) begin
            m_step = step(st_r.month, mlast, rcal_pkg::MONTH_FIRST,
                          st_r.decimal);
            st_nxt.month = m_step[7:0];
            if (m_step[8]) begin
               y_step = step(st_r.year, ylast, rcal_pkg::YEAR_FIRST,
                             st_r.decimal);
               st_nxt.year = y_step[7:0];
               if (y_step[8]) begin
                  c_step = step(st_r.century, ylast, rcal_pkg::YEAR_FIRST,
                                st_r.decimal);
                  st_nxt.century = c_step[7:0];
                  events[rcal_pkg::BIT_ST_ROLL] = 1'h1;
               end
            end
         end

         // Write channels are taken independently, in either order.
         if (s_axi_awvalid_in && st_r.aw_rdy) begin
            st_nxt.aw_got  = 1'h1;
            st_nxt.aw_addr = s_axi_awaddr_in;
         end
         if (s_axi_wvalid_in && st_r.w_rdy) begin
            st_nxt.w_got  = 1'h1;
            st_nxt.w_byte = s_axi_wdata_in[7:0];
            st_nxt.w_lane = s_axi_wstrb_in[0];
         end
         if (st_r.bvalid && s_axi_bready_in) begin
            st_nxt.bvalid = 1'h0;
         end
         // A bus write lands after counting, so software wins a collision.
         if (wr_now) begin
            st_nxt.aw_got = 1'h0;
            st_nxt.w_got  = 1'h0;
            st_nxt.bvalid = 1'h1;
            st_nxt.bresp  = wr_ok ? rcal_pkg::RESP_OKAY : rcal_pkg::RESP_DECERR;
            if (wr_ok && st_r.w_lane) begin
               case (wr_idx)
                  rcal_pkg::IDX_MONTH: begin
                     if (st_r.unlock) begin
                        st_nxt.month = st_r.w_byte;
                     end
                  end
                  rcal_pkg::IDX_YEAR: begin
                     if (st_r.unlock) begin
                        st_nxt.year = st_r.w_byte;
                     end
                  end
                  rcal_pkg::IDX_CENTURY: begin
                     if (st_r.unlock) begin
                        st_nxt.century = st_r.w_byte;
                     end
                  end
                  rcal_pkg::IDX_ALARM_SEC: begin
                     st_nxt.alarm_sec = st_r.w_byte;
                  end
                  rcal_pkg::IDX_ALARM_MIN: begin
                     st_nxt.alarm_min = st_r.w_byte;
                  end
                  rcal_pkg::IDX_ALARM_CTRL: begin
                     st_nxt.alarm_en = st_r.w_byte[1:0];
                  end
                  rcal_pkg::IDX_MODE_CTRL: begin
                     st_nxt.unlock  = st_r.w_byte[rcal_pkg::BIT_UNLOCK];
                     st_nxt.decimal = st_r.w_byte[rcal_pkg::BIT_DECIMAL];
                  end
                  rcal_pkg::IDX_MASK: begin
                     st_nxt.mask = st_r.w_byte[1:0];
                  end
                  default: begin
                     // Status is read-only; a write to it is dropped and still answered OKAY.
                     st_nxt.bresp = rcal_pkg::RESP_OKAY;
                  end
               endcase
            end
         end
         st_nxt.aw_rdy = !st_nxt.aw_got && !st_nxt.bvalid;
         st_nxt.w_rdy  = !st_nxt.w_got && !st_nxt.bvalid;

         // Read: data is sampled at the address edge and held until taken.
         if (st_r.rvalid && s_axi_rready_in) begin
            st_nxt.rvalid = 1'h0;
         end
         if (s_axi_arvalid_in && st_r.ar_rdy) begin
            case (rd_idx)
               rcal_pkg::IDX_MONTH:      rv = st_r.month;
               rcal_pkg::IDX_YEAR:       rv = st_r.year;
               rcal_pkg::IDX_CENTURY:    rv = st_r.century;
               rcal_pkg::IDX_ALARM_SEC:  rv = st_r.alarm_sec;
               rcal_pkg::IDX_ALARM_MIN:  rv = st_r.alarm_min;
               rcal_pkg::IDX_ALARM_CTRL: rv = {6'h00, st_r.alarm_en};
               rcal_pkg::IDX_MODE_CTRL: begin
                  rv = 8'h00;
                  rv[rcal_pkg::BIT_UNLOCK]  = st_r.unlock;
                  rv[rcal_pkg::BIT_DECIMAL] = st_r.decimal;
               end
               rcal_pkg::IDX_STATUS:     rv = {6'h00, st_r.status};
               rcal_pkg::IDX_MASK:       rv = {6'h00, st_r.mask};
               default:                  rv = 8'h00;
            endcase
            st_nxt.rvalid = 1'h1;
            st_nxt.rbyte  = rd_ok ? rv : 8'h00;
            st_nxt.rresp  = rd_ok ? rcal_pkg::RESP_OKAY : rcal_pkg::RESP_DECERR;
            rd_status     = rd_ok && (rd_idx == rcal_pkg::IDX_STATUS);
         end
         st_nxt.ar_rdy = !st_nxt.rvalid;

         // Alarm event on the rising edge of the match condition.
         st_nxt.alarm_match = match_now;
         events[rcal_pkg::BIT_ST_ALARM] = match_now && !st_r.alarm_match;
         // A new event in the clearing read's cycle stays set.
         st_nxt.status = (rd_status ? 2'h0 : st_r.status) | events;
         st_nxt.irq    = (st_nxt.status & st_nxt.mask) != 2'h0;
      end
   end

   // Data registers take no reset value and ride through a reset.
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         st_r.alarm_en    <= rcal_pkg::ALARM_EN_RST;
         st_r.unlock      <= rcal_pkg::UNLOCK_RST;
         st_r.decimal     <= rcal_pkg::DECIMAL_RST;
         st_r.status      <= rcal_pkg::STATUS_RST;
         st_r.mask        <= rcal_pkg::MASK_RST;
         st_r.alarm_match <= 1'h0;
         st_r.irq         <= 1'h0;
         st_r.aw_got      <= 1'h0;
         st_r.w_got       <= 1'h0;
         st_r.aw_addr     <= 12'h000;
         st_r.w_byte      <= 8'h00;
         st_r.w_lane      <= 1'h0;
         st_r.aw_rdy      <= 1'h0;
         st_r.w_rdy       <= 1'h0;
         st_r.bvalid      <= 1'h0;
         st_r.bresp       <= rcal_pkg::RESP_OKAY;
         st_r.ar_rdy      <= 1'h0;
         st_r.rvalid      <= 1'h0;
         st_r.rbyte       <= 8'h00;
         st_r.rresp       <= rcal_pkg::RESP_OKAY;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign s_axi_awready_out = st_r.aw_rdy;
   assign s_axi_wready_out  = st_r.w_rdy;
   assign s_axi_bvalid_out  = st_r.bvalid;
   assign s_axi_bresp_out   = st_r.bresp;
   assign s_axi_arready_out = st_r.ar_rdy;
   assign s_axi_rvalid_out  = st_r.rvalid;
   assign s_axi_rdata_out   = {24'h000000, st_r.rbyte};
   assign s_axi_rresp_out   = st_r.rresp;
   assign alarm_match_out   = st_r.alarm_match;
   assign irq_out           = st_r.irq;

   // Checks sleep while the internal reset is low, when the unreset data registers are unknown.
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n);

   lock_holds_month_a: assert property (
      (ce_in && wr_now && wr_ok && wr_idx == rcal_pkg::IDX_MONTH && !st_r.unlock
       && !month_carry_in) |=> $stable(st_r.month))
      else $error("month changed by a write while locked");

   lock_holds_year_a: assert property (
      (ce_in && wr_now && wr_ok && wr_idx == rcal_pkg::IDX_YEAR && !st_r.unlock
       && !month_carry_in) |=> $stable(st_r.year))
      else $error("year changed by a write while locked");

   alarm_sec_write_a: assert property (
      (ce_in && wr_now && wr_ok && st_r.w_lane && wr_idx == rcal_pkg::IDX_ALARM_SEC)
      |=> st_r.alarm_sec == $past(st_r.w_byte))
      else $error("seconds set point did not take the write");

   month_bin_wrap_a: assert property (
      (ce_in && month_carry_in && !wr_now && !st_r.decimal && st_r.month == 8'h0C)
      |=> st_r.month == 8'h01 && st_r.year != $past(st_r.year))
      else $error("binary month did not wrap from twelve to one");

   month_dec_step_a: assert property (
      (ce_in && month_carry_in && !wr_now && st_r.decimal && st_r.month == 8'h09)
      |=> st_r.month == 8'h10 ##0 $stable(st_r.year))
      else $error("decimal month did not carry nine into ten");

   month_dec_wrap_a: assert property (
      (ce_in && month_carry_in && !wr_now && st_r.decimal && st_r.month == 8'h12)
      |=> st_r.month == 8'h01)
      else $error("decimal month did not wrap from 12 to 01");

   year_roll_a: assert property (
      (ce_in && month_carry_in && !wr_now && !st_r.decimal && st_r.month == 8'h0C
       && st_r.year == 8'h63) |=> st_r.year == 8'h00 && st_r.status[1])
      else $error("binary year wrap did not flag a century roll");

   century_dec_a: assert property (
      (ce_in && month_carry_in && !wr_now && st_r.decimal && st_r.month == 8'h12
       && st_r.year == 8'h99 && st_r.century == 8'h19)
      |=> st_r.century == 8'h20 && st_r.year == 8'h00 && st_r.month == 8'h01)
      else $error("decimal century did not advance from 19 to 20");

   alarm_off_a: assert property (
      (ce_in && st_r.alarm_en == 2'h0) |=> !alarm_match_out)
      else $error("alarm matched with no set point enabled");

   // A repeated match raises no new event, so the flag is owed only on a fresh one.
   alarm_min_only_a: assert property (
      (ce_in && st_r.alarm_en == 2'h2 && st_r.alarm_min == cur_minutes_in)
      |=> alarm_match_out && (st_r.status[0] || $past(st_r.alarm_match)))
      else $error("minutes-only alarm missed its match");

   // A fresh match must survive a status read that lands in the same cycle.
   status_set_wins_a: assert property (
      (ce_in && match_now && !st_r.alarm_match) |=> st_r.status[rcal_pkg::BIT_ST_ALARM])
      else $error("alarm event lost against a status read");

   irq_level_a: assert property (
      (ce_in && (st_r.status & st_r.mask) != 2'h0 && !(s_axi_arvalid_in && st_r.ar_rdy)
       && !wr_now)
      |=> irq_out)
      else $error("interrupt low with an unmasked status bit set");

endmodule : rcal_regs
`default_nettype wire

// ### rtl/rcal_pkg.sv
// Constants for the calendar counter and alarm set-point register block.
// How it works
// - Month counting starts at one, never zero.
// - Binary mode: month holds one to twelve.
// - Decimal mode: month tens 0-1, ones 0-9.
// - Binary mode: year holds zero to ninety-nine.
// - Decimal mode: year holds two packed digits.
// - Binary mode: century holds zero to ninety-nine.
// - Decimal mode: century holds two packed digits.
// - Binary mode: seconds alarm zero to fifty-nine.
// - Decimal mode: seconds alarm tens 0-5, ones 0-9.
// - Binary mode: minutes alarm zero to fifty-nine.
// - Decimal mode: minutes alarm tens 0-5, ones 0-9.
// - Month, year, century writable only while unlocked.
// - Reset leaves all five data registers unchanged.
// - Decimal flag selects binary or packed decimal format.
// - Alarm set points writable regardless of lock.
// - Decimal flag makes counting decimal; alarm comparison is raw in either mode.
// - Seconds alarm matches only when enable bit0 set.
// - Minutes alarm matches only when enable bit1 set.
package rcal_pkg;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 32;
   // Register indices; the byte address is four times the index.
   localparam logic [7:0] IDX_MONTH      = 8'hE5;
   localparam logic [7:0] IDX_YEAR       = 8'hE6;
   localparam logic [7:0] IDX_CENTURY    = 8'hE7;
   localparam logic [7:0] IDX_ALARM_SEC  = 8'hE8;
   localparam logic [7:0] IDX_ALARM_MIN  = 8'hE9;
   localparam logic [7:0] IDX_ALARM_CTRL = 8'hEC;
   localparam logic [7:0] IDX_MODE_CTRL  = 8'hED;
   localparam logic [7:0] IDX_STATUS     = 8'hF0;
   localparam logic [7:0] IDX_MASK       = 8'hF1;
   // Field positions.
   localparam int unsigned BIT_SEC_EN   = 0;
   localparam int unsigned BIT_MIN_EN   = 1;
   localparam int unsigned BIT_UNLOCK   = 0;
   localparam int unsigned BIT_DECIMAL  = 5;
   localparam int unsigned BIT_ST_ALARM = 0;
   localparam int unsigned BIT_ST_ROLL  = 1;
   // Counting limits in both formats.
   localparam logic [7:0] MONTH_FIRST    = 8'h01;
   localparam logic [7:0] MONTH_LAST_BIN = 8'h0C;
   localparam logic [7:0] MONTH_LAST_DEC = 8'h12;
   localparam logic [7:0] YEAR_FIRST     = 8'h00;
   localparam logic [7:0] YEAR_LAST_BIN  = 8'h63;
   localparam logic [7:0] YEAR_LAST_DEC  = 8'h99;
   localparam logic [3:0] DIGIT_LAST     = 4'h9;
   // Reset values of the control state.
   localparam logic [1:0] ALARM_EN_RST = 2'h0;
   localparam logic       UNLOCK_RST   = 1'h0;
   localparam logic       DECIMAL_RST  = 1'h0;
   localparam logic [1:0] STATUS_RST   = 2'h0;
   localparam logic [1:0] MASK_RST     = 2'h0;
   // Bus responses.
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage : rcal_pkg

// ### bench/tb_top.sv
// Self-checking bench for the calendar counter and alarm set-point register block.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic             clk_in;
   logic             rst_n_in;
   logic             carry_r;
   logic [7:0]       sec_r;
   logic [7:0]       min_r;
   logic [11:0]      awaddr;
   logic [11:0]      araddr;
   logic [31:0]      wdata;
   logic [3:0]       wstrb;
   logic             awvalid;
   logic             wvalid;
   logic             bready;
   logic             arvalid;
   logic             rready;
   logic [1:0]       wr_resp;
   wire logic        awready;
   wire logic        wready;
   wire logic        bvalid;
   wire logic        arready;
   wire logic        rvalid;
   wire logic        match;
   wire logic        irq;
   wire logic [1:0]  bresp;
   wire logic [1:0]  rresp;
   wire logic [31:0] rdata;
   int               n_fail;
   int               comparisons;

   rcal_regs dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(1'b1),
      .month_carry_in(carry_r), .cur_seconds_in(sec_r), .cur_minutes_in(min_r),
      .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
      .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
      .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
      .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
      .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
      .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .alarm_match_out(match),
      .irq_out(irq));

   initial begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end

   function automatic logic [11:0] ba(input logic [7:0] idx);
      return {2'h0, idx, 2'h0};
   endfunction : ba

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, seen, exp);
      end
   endtask : chk

   // Handshakes are read at the falling edge, where they already stand for the next rising one.
   task automatic wr(input logic [11:0] a, input logic [7:0] v, input logic [3:0] s = 4'hF);
      bit aw_take;
      bit w_take;
      @(posedge clk_in);
      awaddr <= a;
      wdata <= {24'h0, v};
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(negedge clk_in);
         aw_take = awvalid && (awready === 1'b1);
         w_take = wvalid && (wready === 1'b1);
         @(posedge clk_in);
         if (aw_take) begin
            awvalid <= 1'b0;
         end
         if (w_take) begin
            wvalid <= 1'b0;
         end
      end while (!((aw_take || !awvalid) && (w_take || !wvalid)));
      do begin
         @(negedge clk_in);
      end while (bvalid !== 1'b1);
      wr_resp = bresp;
      @(posedge clk_in);
      bready <= 1'b0;
   endtask : wr

   task automatic rdchk(input logic [11:0] a, input logic [7:0] exp,
                        input logic [1:0] rexp = 2'h0);
      bit          ar_take;
      bit          got;
      logic [31:0] d;
      logic [1:0]  r;
      @(posedge clk_in);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(negedge clk_in);
         ar_take = arvalid && (arready === 1'b1);
         got = (rvalid === 1'b1);
         d = rdata;
         r = rresp;
         @(posedge clk_in);
         if (ar_take) begin
            arvalid <= 1'b0;
         end
      end while (!got);
      rready <= 1'b0;
      chk(d, {24'h0, exp}, "read data");
      chk({30'h0, r}, {30'h0, rexp}, "read response");
   endtask : rdchk

   task automatic pulse_carry();
      @(posedge clk_in);
      carry_r <= 1'b1;
      @(posedge clk_in);
      carry_r <= 1'b0;
      repeat (2) @(posedge clk_in);
   endtask : pulse_carry

   task automatic do_reset();
      rst_n_in <= 1'b0;
      repeat (5) @(posedge clk_in);
      rst_n_in <= 1'b1;
      repeat (4) @(posedge clk_in);
   endtask : do_reset

   task automatic t_lock();
      wr(ba(rcal_pkg::IDX_MODE_CTRL), 8'h01);
      wr(ba(rcal_pkg::IDX_YEAR), 8'h11);
      wr(ba(rcal_pkg::IDX_MONTH), 8'h0B);
      wr(ba(rcal_pkg::IDX_MODE_CTRL), 8'h00);
      wr(ba(rcal_pkg::IDX_YEAR), 8'h55);
      chk({30'h0, wr_resp}, {30'h0, rcal_pkg::RESP_OKAY}, "locked write");
      wr(ba(rcal_pkg::IDX_MONTH), 8'h02);
      rdchk(ba(rcal_pkg::IDX_YEAR), 8'h11);
      rdchk(ba(rcal_pkg::IDX_MONTH), 8'h0B);
      wr(ba(rcal_pkg::IDX_ALARM_SEC), 8'h3B);
      wr(ba(rcal_pkg::IDX_ALARM_MIN), 8'h00);
      rdchk(ba(rcal_pkg::IDX_ALARM_SEC), 8'h3B);
      rdchk(ba(rcal_pkg::IDX_ALARM_MIN), 8'h00);
      rdchk(ba(8'hEA), 8'h00, rcal_pkg::RESP_DECERR);
      wr(12'h395, 8'h07);
      chk({30'h0, wr_resp}, {30'h0, rcal_pkg::RESP_DECERR}, "misaligned write");
   endtask : t_lock

   task automatic t_binary();
      wr(ba(rcal_pkg::IDX_MODE_CTRL), 8'h01);
      wr(ba(rcal_pkg::IDX_MONTH), 8'h0C);
      wr(ba(rcal_pkg::IDX_YEAR), 8'h63);
      wr(ba(rcal_pkg::IDX_CENTURY), 8'h05);
      pulse_carry();
      rdchk(ba(rcal_pkg::IDX_MONTH), 8'h01);
      rdchk(ba(rcal_pkg::IDX_YEAR), 8'h00);
      rdchk(ba(rcal_pkg::IDX_CENTURY), 8'h06);
      rdchk(ba(rcal_pkg::IDX_STATUS), 8'h02);
      rdchk(ba(rcal_pkg::IDX_STATUS), 8'h00);
      wr(ba(rcal_pkg::IDX_MONTH), 8'h09, 4'hE);
      rdchk(ba(rcal_pkg::IDX_MONTH), 8'h01);
   endtask : t_binary

   task automatic t_decimal();
      wr(ba(rcal_pkg::IDX_MODE_CTRL), 8'h21);
      wr(ba(rcal_pkg::IDX_MONTH), 8'h09);
      pulse_carry();
      rdchk(ba(rcal_pkg::IDX_MONTH), 8'h10);
      wr(ba(rcal_pkg::IDX_MONTH), 8'h12);
      wr(ba(rcal_pkg::IDX_YEAR), 8'h99);
      wr(ba(rcal_pkg::IDX_CENTURY), 8'h19);
      pulse_carry();
      rdchk(ba(rcal_pkg::IDX_MONTH), 8'h01);
      rdchk(ba(rcal_pkg::IDX_YEAR), 8'h00);
      rdchk(ba(rcal_pkg::IDX_CENTURY), 8'h20);
      rdchk(ba(rcal_pkg::IDX_STATUS), 8'h02);
   endtask : t_decimal

   task automatic t_alarm();
      wr(ba(rcal_pkg::IDX_ALARM_SEC), 8'h30);
      wr(ba(rcal_pkg::IDX_ALARM_MIN), 8'h45);
      rdchk(ba(rcal_pkg::IDX_ALARM_MIN), 8'h45);
      sec_r <= 8'h30;
      min_r <= 8'h44;
      wr(ba(rcal_pkg::IDX_ALARM_CTRL), 8'h01);
      repeat (3) @(posedge clk_in);
      chk({31'h0, match}, 32'h1, "seconds only match");
      chk({31'h0, irq}, 32'h0, "masked interrupt");
      wr(ba(rcal_pkg::IDX_ALARM_CTRL), 8'h03);
      repeat (3) @(posedge clk_in);
      chk({31'h0, match}, 32'h0, "minutes differ");
      wr(ba(rcal_pkg::IDX_MASK), 8'h01);
      chk({31'h0, irq}, 32'h1, "pending unmasked");
      rdchk(ba(rcal_pkg::IDX_STATUS), 8'h01);
      repeat (2) @(posedge clk_in);
      chk({31'h0, irq}, 32'h0, "cleared interrupt");
      min_r <= 8'h45;
      repeat (3) @(posedge clk_in);
      chk({31'h0, match}, 32'h1, "both match");
      chk({31'h0, irq}, 32'h1, "new event");
      sec_r <= 8'h31;
      wr(ba(rcal_pkg::IDX_ALARM_CTRL), 8'h02);
      repeat (3) @(posedge clk_in);
      chk({31'h0, match}, 32'h1, "minutes only match");
      wr(ba(rcal_pkg::IDX_ALARM_CTRL), 8'h00);
      repeat (3) @(posedge clk_in);
      chk({31'h0, match}, 32'h0, "no enable");
      rdchk(ba(rcal_pkg::IDX_STATUS), 8'h01);
   endtask : t_alarm

   task automatic t_reset_keep();
      do_reset();
      rdchk(ba(rcal_pkg::IDX_MONTH), 8'h01);
      rdchk(ba(rcal_pkg::IDX_CENTURY), 8'h20);
      rdchk(ba(rcal_pkg::IDX_ALARM_SEC), 8'h30);
      rdchk(ba(rcal_pkg::IDX_ALARM_MIN), 8'h45);
      rdchk(ba(rcal_pkg::IDX_ALARM_CTRL), 8'h00);
      rdchk(ba(rcal_pkg::IDX_MODE_CTRL), 8'h00);
      chk({31'h0, irq}, 32'h0, "interrupt after reset");
   endtask : t_reset_keep

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      #400000;
      n_fail++;
      tally_and_finish();
   end

   initial begin
      {carry_r, awvalid, wvalid, bready, arvalid, rready} = '0;
      {sec_r, min_r, awaddr, araddr, wdata, wstrb} = '0;
      n_fail = 0;
      comparisons = 0;
      rst_n_in = 1'b0;
      do_reset();
      t_lock();
      t_binary();
      t_decimal();
      t_alarm();
      t_reset_keep();
      tally_and_finish();
   end
endmodule : tb_top
`default_nettype wire
